/* File: inc/spf_pkg.sv */
// Purpose: constants and carriers for the servo parameter and pulse front end
// Assumes: 12-bit parameter words, 40 MHz mclk
// Notes: parameter numbers double as register indices; byte address is not used
package spf_pkg;
    localparam int unsigned MCLK_HZ = 40000000;
    localparam int unsigned MS_CYCLES = MCLK_HZ / 1000;
    localparam int unsigned NUM_PARAMS = 35;
    localparam logic [5:0] PNUM_BRAKE = 6'h00;
    localparam logic [5:0] PNUM_TUNE = 6'h01;
    localparam logic [5:0] PNUM_GNUM = 6'h02;
    localparam logic [5:0] PNUM_GDEN = 6'h03;
    localparam logic [5:0] PNUM_SMOOTH = 6'h04;
    localparam logic [5:0] PNUM_INPOS = 6'h05;
    localparam logic [5:0] PNUM_INFUNC = 6'h06;
    localparam logic [5:0] PNUM_PFORM = 6'h07;
    localparam logic [5:0] PNUM_TORQ = 6'h09;
    localparam logic [5:0] PNUM_LOCK = 6'h0c;
    localparam logic [5:0] PNUM_MAX_BASIC = 6'h0c;
    localparam logic [5:0] PNUM_MAX_EXP = 6'h16;
    localparam logic [5:0] PNUM_MAX_ALL = 6'h22;
    localparam logic [5:0] PNUM_STATUS = 6'h30;
    localparam logic [11:0] RST_BRAKE = 12'h000;
    localparam logic [11:0] RST_TUNE = 12'h002;
    localparam logic [11:0] RST_GNUM = 12'h001;
    localparam logic [11:0] RST_GDEN = 12'h001;
    localparam logic [11:0] RST_SMOOTH = 12'h005;
    localparam logic [11:0] RST_INPOS = 12'h064;
    localparam logic [11:0] RST_INFUNC = 12'h010;
    localparam logic [11:0] RST_PFORM = 12'h010;
    localparam logic [11:0] RST_TORQ = 12'h064;
    localparam logic [11:0] RST_LOCK = 12'h000;
    localparam logic [11:0] MAX_BRAKE = 12'h102;
    localparam logic [11:0] MIN_TUNE = 12'h001;
    localparam logic [11:0] MAX_TUNE = 12'h235;
    localparam logic [11:0] MAX_GEAR = 12'd999;
    localparam logic [11:0] MAX_SMOOTH = 12'd999;
    localparam logic [11:0] MAX_INPOS = 12'd999;
    localparam logic [11:0] MAX_INFUNC = 12'h111;
    localparam logic [11:0] MAX_PFORM = 12'h012;
    localparam logic [11:0] MAX_TORQ = 12'd100;
    localparam logic [11:0] LOCK_NONE = 12'h000;
    localparam logic [11:0] LOCK_ONLY12 = 12'h00a;
    localparam logic [11:0] LOCK_RD22 = 12'h00b;
    localparam logic [11:0] LOCK_RW22 = 12'h00c;
    localparam logic [11:0] LOCK_ALL = 12'h00d;
    localparam int unsigned FORM_LSB = 0;
    localparam int unsigned LOGIC_BIT = 4;
    localparam int unsigned SON_POL_BIT = 0;
    localparam int unsigned STROKE_BIT = 4;
    localparam logic [7:0] TORQ_FULL = 8'd100;
    typedef enum logic [1:0] {
        SPF_FORM_FWD_REV = 2'b00,
        SPF_FORM_PULSE_SIGN = 2'b01,
        SPF_FORM_QUAD = 2'b10
    } spf_form_e;
    typedef struct packed {
        logic [5:0] addr;
        logic [11:0] wdata;
        logic wr;
        logic rd;
    } spf_bus_s;
    typedef struct packed {
        logic pulse_a;
        logic pulse_b;
    } spf_pulse_s;
endpackage

/* File: tb/servo_param_pulse_front_end_tb.sv */
// Purpose: self-checking bench for the parameter store and pulse front end
// Assumes: stored parameters survive rst_b, which marks a power cycle
// Notes: host never touches the manufacturer slots
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("wrong value %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module servo_param_pulse_front_end_tb;
    import spf_pkg::*;
    localparam logic [5:0] DA [10] = '{PNUM_BRAKE, PNUM_TUNE, PNUM_GNUM, PNUM_GDEN,
        PNUM_SMOOTH, PNUM_INPOS, PNUM_INFUNC, PNUM_PFORM, PNUM_TORQ, PNUM_LOCK};
    localparam logic [11:0] DV [10] = '{12'h000, 12'h002, 12'h001, 12'h001, 12'h005,
        12'h064, 12'h010, 12'h010, 12'h064, 12'h000};
    localparam logic [5:0] RA [8] = '{PNUM_GNUM, PNUM_GDEN, PNUM_SMOOTH, PNUM_INPOS,
        PNUM_TORQ, PNUM_INFUNC, PNUM_PFORM, PNUM_LOCK};
    localparam logic [11:0] RLO [8] = '{12'h001, 12'h001, 12'h000, 12'h000, 12'h000,
        12'h000, 12'h000, 12'h000};
    localparam logic [11:0] RHI [8] = '{12'h3e7, 12'h3e7, 12'h3e7, 12'h3e7, 12'h064,
        12'h111, 12'h012, 12'h00d};
    localparam logic [11:0] RBAD [8] = '{12'h000, 12'h3e8, 12'h3e8, 12'h3e8, 12'h065,
        12'h112, 12'h013, 12'h00e};
    localparam logic [11:0] LK [5] = '{12'h000, 12'h00a, 12'h00b, 12'h00c, 12'h00d};
    logic mclk;
    logic rst_b;
    spf_bus_s bus;
    logic [11:0] rdata;
    spf_pulse_s pins;
    logic servo_on_input;
    logic forward_stroke_limit;
    logic reverse_stroke_limit;
    logic fb_step;
    logic fb_dir;
    logic servo_enable;
    logic fwd_allowed;
    logic rev_allowed;
    logic positioning_finished;
    logic [7:0] torque_limit;
    logic signed [23:0] pos_command;
    logic go;
    logic neg;
    spf_form_e form;
    logic [7:0] cnt;
    logic busy;
    int failures;
    int cmp_count;
    int seed;
    int exp_pos;
    int fb;
    int num;
    int den;
    int k;
    int prev_tq;
    int t;
    logic [11:0] v;

    spf_front_end u_dut (.mclk(mclk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
        .pulse_in(pins), .servo_on_input(servo_on_input),
        .forward_stroke_limit(forward_stroke_limit),
        .reverse_stroke_limit(reverse_stroke_limit), .fb_step(fb_step), .fb_dir(fb_dir),
        .servo_enable(servo_enable), .fwd_allowed(fwd_allowed), .rev_allowed(rev_allowed),
        .positioning_finished(positioning_finished), .torque_limit(torque_limit),
        .pos_command(pos_command));
    spf_pulse_src u_src (.mclk(mclk), .rst_b(rst_b), .go(go), .form(form), .neg(neg),
        .cnt(cnt), .busy(busy), .pins(pins));

    // param 13 only visible and written in the wide ranges
    function automatic logic [11:0] exp_p13(input logic [11:0] lk);
        if (lk == LOCK_RW22 || lk == LOCK_ALL)
            return 12'h011;
        return 12'h000;
    endfunction

    // one ms tick moves 1/tc of the gap, at least one count
    function automatic int smooth_exp(input int gap, input int tc);
        if (gap / tc == 0)
            return 1;
        return gap / tc;
    endfunction

    task automatic send_train();
        cnt <= 8'(den * k);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (2) @(posedge mclk);
        for (t = 0; t < 3000 && busy; t++)
            @(posedge mclk);
        `CHK("busy", 1'b0, busy)
        repeat (8) @(posedge mclk);
    endtask

    task automatic end_sim();
        if (failures == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [11:0] d);
        @(posedge mclk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask

    task automatic rchk(input logic [5:0] a, input logic [11:0] e);
        @(posedge mclk);
        bus <= '{a, 12'h000, 1'b0, 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial
    begin
        repeat (80000) @(posedge mclk);
        failures++;
        end_sim();
    end

    initial
    begin
        failures = 0;
        cmp_count = 0;
        rst_b = 1'b0;
        bus = '0;
        servo_on_input = 1'b0;
        forward_stroke_limit = 1'b0;
        reverse_stroke_limit = 1'b0;
        fb_step = 1'b0;
        fb_dir = 1'b0;
        go = 1'b0;
        neg = 1'b0;
        form = SPF_FORM_FWD_REV;
        cnt = 8'h00;
        seed = $urandom(39543);
        do_reset();
        `CHK("torque_limit", 8'h64, torque_limit)
        foreach (DA[i])
            rchk(DA[i], DV[i]);
        // slot 8 is never written by this host
        foreach (RA[i])
        begin
            wr(RA[i], RHI[i]);
            wr(RA[i], RBAD[i]);
            rchk(RA[i], RHI[i]);
            if (i < 5)
            begin
                v = RLO[i] + 12'($urandom % (RHI[i] - RLO[i] + 1));
                wr(RA[i], v);
                rchk(RA[i], v);
            end
            wr(RA[i], RLO[i]);
            rchk(RA[i], RLO[i]);
        end
        `CHK("torque_limit", 8'h00, torque_limit)
        // effective lock still 000 from reset, so param 13 is neither written nor read
        wr(6'h0d, 12'h011);
        rchk(6'h0d, 12'h000);
        rchk(6'h3f, 12'h000);
        repeat (4) @(posedge mclk);
        `CHK("fwd_allowed", 1'b1, fwd_allowed)
        do_reset();
        repeat (4) @(posedge mclk);
        `CHK("fwd_allowed", 1'b0, fwd_allowed)
        `CHK("rev_allowed", 1'b0, rev_allowed)
        forward_stroke_limit <= 1'b1;
        reverse_stroke_limit <= 1'b1;
        servo_on_input <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK("fwd_allowed", 1'b1, fwd_allowed)
        `CHK("rev_allowed", 1'b1, rev_allowed)
        `CHK("servo_enable", 1'b1, servo_enable)
        wr(PNUM_INFUNC, 12'h001);
        do_reset();
        repeat (4) @(posedge mclk);
        `CHK("servo_enable", 1'b0, servo_enable)
        servo_on_input <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK("servo_enable", 1'b1, servo_enable)
        prev_tq = 0;
        foreach (LK[i])
        begin
            wr(PNUM_LOCK, LK[i]);
            do_reset();
            rchk(PNUM_LOCK, LK[i]);
            wr(6'h0d, 12'h011);
            wr(PNUM_TORQ, 12'(20 + i));
            if (LK[i] != LOCK_ONLY12)
                prev_tq = 20 + i;
            rchk(6'h0d, exp_p13(LK[i]));
            rchk(6'h17, 12'h000);
            `CHK("torque_limit", 8'(prev_tq), torque_limit)
        end
        for (int f = 0; f < 6; f++)
        begin
            num = 1 + $urandom % 9;
            den = 1 + $urandom % 9;
            k = 1 + $urandom % 4;
            wr(PNUM_GNUM, 12'(num));
            wr(PNUM_GDEN, 12'(den));
            wr(PNUM_INPOS, 12'h003);
            wr(PNUM_PFORM, {7'h00, f[0], 2'h0, 2'(f / 2)});
            form <= spf_form_e'(2'(f / 2));
            neg <= f[0];
            do_reset();
            send_train();
            exp_pos = k * num;
            `CHK("pos_command", 24'(exp_pos), pos_command)
            for (fb = 0; fb <= exp_pos; fb++)
            begin
                `CHK("positioning_finished", (exp_pos - fb <= 3), positioning_finished)
                fb_step <= 1'b1;
                @(posedge mclk);
                fb_step <= 1'b0;
                repeat (4) @(posedge mclk);
            end
        end
        wr(PNUM_SMOOTH, 12'h002);
        do_reset();
        send_train();
        #1;
        `CHK("pos_command", 24'h000000, pos_command)
        repeat (MS_CYCLES) @(posedge mclk);
        #1;
        `CHK("pos_command", 24'(smooth_exp(exp_pos, 2)), pos_command)
        end_sim();
    end
endmodule

/* File: tb/spf_pulse_src.sv */
// Purpose: external positioning controller issuing command pulse trains
// Assumes: one forward train per go request, go only while busy is low
// Notes: each level held 8 mclk cycles; idle level follows the pulse logic
`timescale 1ns/1ps
module spf_pulse_src
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic go,
    input wire spf_pkg::spf_form_e form,
    input wire logic neg,
    input wire logic [7:0] cnt,
    output logic busy,
    output spf_pkg::spf_pulse_s pins
);
    import spf_pkg::*;
    logic [7:0] left;
    logic [2:0] ph;
    logic a_raw;
    logic b_raw;
    // negative logic inverts both lines, idle included
    assign pins = {a_raw ^ neg, b_raw ^ neg};
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy <= 1'b0;
            left <= 8'h00;
            ph <= 3'h0;
            a_raw <= 1'b0;
            b_raw <= 1'b0;
        end
        else if (!busy)
        begin
            busy <= go && cnt != 8'h00;
            left <= cnt;
            ph <= 3'h0;
        end
        else if (ph != 3'h7)
        begin
            ph <= ph + 3'h1;
        end
        else if (form == SPF_FORM_QUAD)
        begin
            // b leads a for forward travel, one count per edge
            a_raw <= b_raw;
            b_raw <= ~a_raw;
            left <= left - 8'h01;
            busy <= left != 8'h01;
            ph <= 3'h0;
        end
        else
        begin
            // forward pulses on line a, line b held inactive
            a_raw <= ~a_raw;
            ph <= 3'h0;
            if (a_raw)
            begin
                left <= left - 8'h01;
                busy <= left != 8'h01;
            end
        end
    end
endmodule

/* File: verilog/spf_front_end.sv */
// Purpose: parameter store and command pulse front end of a servo amplifier
// Assumes: rst_b low marks power-on; pins synchronous to mclk
// Notes: droop is command minus feedback, feedback given as signed steps
`timescale 1ns/1ps
module spf_front_end
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire spf_pkg::spf_bus_s bus,
    output logic [11:0] rdata,
    input wire spf_pkg::spf_pulse_s pulse_in,
    input wire logic servo_on_input,
    input wire logic forward_stroke_limit,
    input wire logic reverse_stroke_limit,
    input wire logic fb_step,
    input wire logic fb_dir,
    output logic servo_enable,
    output logic fwd_allowed,
    output logic rev_allowed,
    output logic positioning_finished,
    output logic [7:0] torque_limit,
    output logic signed [23:0] pos_command
);
    import spf_pkg::*;
    // non-volatile store: contents kept through rst_b, factory defaults at start
    logic [11:0] store [NUM_PARAMS] = '{PNUM_BRAKE: RST_BRAKE, PNUM_TUNE: RST_TUNE,
        PNUM_GNUM: RST_GNUM, PNUM_GDEN: RST_GDEN, PNUM_SMOOTH: RST_SMOOTH,
        PNUM_INPOS: RST_INPOS, PNUM_INFUNC: RST_INFUNC, PNUM_PFORM: RST_PFORM,
        PNUM_TORQ: RST_TORQ, PNUM_LOCK: RST_LOCK, default: 12'h000};
    logic [11:0] eff [NUM_PARAMS];
    logic [11:0] eff_lock;
    logic wr_ok;
    logic rd_ok;
    logic val_ok;
    logic [1:0] sa;
    logic [1:0] sb;
    logic step;
    logic dir;
    logic g_valid;
    logic signed [11:0] g_delta;
    logic signed [23:0] target;
    logic signed [23:0] feedback;
    logic signed [23:0] droop;
    logic [15:0] ms_cnt;
    logic [1:0] boot_sr;

    function automatic logic is_power_cycle(input logic [5:0] n);
        is_power_cycle = (n == PNUM_BRAKE) || (n == PNUM_INFUNC) || (n == PNUM_PFORM)
            || (n == PNUM_LOCK);
    endfunction

    function automatic logic [11:0] reset_of(input logic [5:0] n);
        case (n)
            PNUM_BRAKE: reset_of = RST_BRAKE;
            PNUM_TUNE: reset_of = RST_TUNE;
            PNUM_GNUM: reset_of = RST_GNUM;
            PNUM_GDEN: reset_of = RST_GDEN;
            PNUM_SMOOTH: reset_of = RST_SMOOTH;
            PNUM_INPOS: reset_of = RST_INPOS;
            PNUM_INFUNC: reset_of = RST_INFUNC;
            PNUM_PFORM: reset_of = RST_PFORM;
            PNUM_TORQ: reset_of = RST_TORQ;
            PNUM_LOCK: reset_of = RST_LOCK;
            default: reset_of = 12'h000;
        endcase
    endfunction

    // lock decode for the read check; write_allowed decodes the write check
    function automatic logic [5:0] read_top(input logic [11:0] lk);
        read_top = (lk == LOCK_NONE || lk == LOCK_ONLY12) ? PNUM_MAX_BASIC : PNUM_MAX_EXP;
    endfunction

    function automatic logic write_allowed(input logic [11:0] lk, input logic [5:0] n);
        case (lk)
            LOCK_NONE: write_allowed = n <= PNUM_MAX_BASIC;
            LOCK_ONLY12: write_allowed = n == PNUM_LOCK;
            LOCK_RD22: write_allowed = n <= PNUM_MAX_BASIC;
            LOCK_RW22: write_allowed = n <= PNUM_MAX_EXP;
            LOCK_ALL: write_allowed = n <= PNUM_MAX_ALL;
            default: write_allowed = n <= PNUM_MAX_BASIC;
        endcase
    endfunction

    function automatic logic in_range(input logic [5:0] n, input logic [11:0] v);
        case (n)
            PNUM_BRAKE: in_range = v <= MAX_BRAKE && v[7:4] == 4'h0 && v[3:0] <= 4'h2;
            PNUM_TUNE: in_range = v >= MIN_TUNE && v <= MAX_TUNE;
            PNUM_GNUM, PNUM_GDEN: in_range = v != 12'h000 && v <= MAX_GEAR;
            PNUM_SMOOTH: in_range = v <= MAX_SMOOTH;
            PNUM_INPOS: in_range = v <= MAX_INPOS;
            PNUM_INFUNC: in_range = v <= MAX_INFUNC && v[3:0] <= 4'h1 && v[7:4] <= 4'h1;
            PNUM_PFORM: in_range = v <= MAX_PFORM && v[3:0] <= 4'h2;
            PNUM_TORQ: in_range = v <= MAX_TORQ;
            PNUM_LOCK: in_range = v == LOCK_NONE || (v >= LOCK_ONLY12 && v <= LOCK_ALL);
            default: in_range = 1'b1;
        endcase
    endfunction

    assign eff_lock = eff[PNUM_LOCK];
    assign val_ok = in_range(bus.addr, bus.wdata);
    assign wr_ok = bus.wr && write_allowed(eff_lock, bus.addr) && val_ok;
    assign rd_ok = bus.addr <= read_top(eff_lock);

    // bit 0: power-cycle values loaded, bit 1: pulse pins resampled
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            boot_sr <= 2'b00;
        end
        else
        begin
            boot_sr <= {boot_sr[0], 1'b1};
        end
    end

    // written values land in the store; effective copies follow
    generate
        for (genvar i = 0; i < NUM_PARAMS; i++)
        begin : g_param
            always_ff @(posedge mclk)
            begin
                if (wr_ok && bus.addr == 6'(i))
                begin
                    store[i] <= bus.wdata;
                end
            end
            // power-cycle parameters reload only at reset release
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    eff[i] <= reset_of(6'(i));
                end
                else if (!boot_sr[0] || !is_power_cycle(6'(i)))
                begin
                    eff[i] <= store[i];
                end
            end
        end
    endgenerate

    // numbers outside the read range read back as zero, except the status word
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata <= 12'h000;
        end
        else if (bus.rd)
        begin
            if (bus.addr == PNUM_STATUS)
            begin
                rdata <= {positioning_finished, servo_enable, fwd_allowed, rev_allowed, 8'h00};
            end
            else if (rd_ok && bus.addr < 6'(NUM_PARAMS))
            begin
                rdata <= store[bus.addr];
            end
            else
            begin
                rdata <= 12'h000;
            end
        end
    end

    // pulse decode
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sa <= 2'b00;
            sb <= 2'b00;
        end
        else if (!boot_sr[1])
        begin
            // both taps equal while polarity loads, so no false edge after reset
            sa <= {2{pulse_in.pulse_a ^ eff[PNUM_PFORM][LOGIC_BIT]}};
            sb <= {2{pulse_in.pulse_b ^ eff[PNUM_PFORM][LOGIC_BIT]}};
        end
        else
        begin
            sa <= {sa[0], pulse_in.pulse_a ^ eff[PNUM_PFORM][LOGIC_BIT]};
            sb <= {sb[0], pulse_in.pulse_b ^ eff[PNUM_PFORM][LOGIC_BIT]};
        end
    end

    always_comb
    begin
        step = 1'b0;
        dir = 1'b0;
        case (spf_form_e'(eff[PNUM_PFORM][FORM_LSB +: 2]))
            SPF_FORM_FWD_REV:
            begin
                step = (sa == 2'b01) ^ (sb == 2'b01);
                dir = sb == 2'b01;
            end
            SPF_FORM_PULSE_SIGN:
            begin
                step = sa == 2'b01;
                dir = sb[0];
            end
            SPF_FORM_QUAD:
            begin
                step = (sa[1] ^ sa[0]) ^ (sb[1] ^ sb[0]);
                dir = sa[0] ^ sb[1];
            end
            default:
            begin
                step = 1'b0;
                dir = 1'b0;
            end
        endcase
    end

    spf_gear u_gear
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .step(step),
        .dir(dir),
        .gear_numerator(eff[PNUM_GNUM]),
        .gear_denominator(eff[PNUM_GDEN]),
        .out_valid(g_valid),
        .out_delta(g_delta)
    );

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            target <= 24'sh000000;
            feedback <= 24'sh000000;
        end
        else
        begin
            if (g_valid)
            begin
                target <= target + 24'(g_delta);
            end
            if (fb_step)
            begin
                feedback <= fb_dir ? feedback - 24'sd1 : feedback + 24'sd1;
            end
        end
    end

    // first-order smoothing: each tick moves 1/tc of the gap, tc in ms
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ms_cnt <= 16'h0000;
            pos_command <= 24'sh000000;
        end
        else if (eff[PNUM_SMOOTH] == 12'h000)
        begin
            pos_command <= target;
        end
        else if (ms_cnt == 16'(MS_CYCLES - 1))
        begin
            ms_cnt <= 16'h0000;
            pos_command <= pos_command + (target - pos_command) / $signed({13'h0000, eff[PNUM_SMOOTH][10:0]});
            if (target != pos_command && (target - pos_command) / $signed({13'h0000,
                eff[PNUM_SMOOTH][10:0]}) == 24'sh0)
            begin
                pos_command <= target > pos_command ? pos_command + 24'sd1 : pos_command - 24'sd1;
            end
        end
        else
        begin
            ms_cnt <= ms_cnt + 16'h0001;
        end
    end

    assign droop = pos_command - feedback;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            positioning_finished <= 1'b0;
            servo_enable <= 1'b0;
            fwd_allowed <= 1'b0;
            rev_allowed <= 1'b0;
            torque_limit <= TORQ_FULL;
        end
        else
        begin
            positioning_finished <= (droop >= -$signed({12'h000, eff[PNUM_INPOS]}))
                && (droop <= $signed({12'h000, eff[PNUM_INPOS]}));
            servo_enable <= servo_on_input ^ eff[PNUM_INFUNC][SON_POL_BIT];
            fwd_allowed <= eff[PNUM_INFUNC][STROKE_BIT] ? 1'b1 : forward_stroke_limit;
            rev_allowed <= eff[PNUM_INFUNC][STROKE_BIT] ? 1'b1 : reverse_stroke_limit;
            torque_limit <= eff[PNUM_TORQ][7:0];
        end
    end

    chk_lock_write_block: assert property (@(posedge mclk) disable iff (!rst_b)
        bus.wr && eff_lock == LOCK_ONLY12 && bus.addr != PNUM_LOCK
        |=> $stable(store[PNUM_GNUM]))
        else $error("write passed under lock 00a");
    chk_power_cycle_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        boot_sr[0] |=> $stable(eff[PNUM_PFORM]))
        else $error("power-cycle parameter changed without reset");
    chk_range_reject: assert property (@(posedge mclk) disable iff (!rst_b)
        bus.wr && bus.addr == PNUM_TORQ && bus.wdata > MAX_TORQ
        |=> $stable(store[PNUM_TORQ]))
        else $error("torque value above range stored");
    chk_read_hidden: assert property (@(posedge mclk) disable iff (!rst_b)
        bus.rd && eff_lock == LOCK_NONE && bus.addr > PNUM_MAX_BASIC && bus.addr < PNUM_STATUS
        |=> rdata == 12'h000)
        else $error("read outside range returned data");
    chk_inpos_flag: assert property (@(posedge mclk) disable iff (!rst_b)
        droop == 24'sh0 |=> positioning_finished)
        else $error("zero droop without finished flag");
    chk_servo_pol: assert property (@(posedge mclk) disable iff (!rst_b)
        boot_sr[0] |=> servo_enable == ($past(servo_on_input) ^ eff[PNUM_INFUNC][SON_POL_BIT]))
        else $error("servo-on polarity wrong");
    chk_torque_cap: assert property (@(posedge mclk) disable iff (!rst_b)
        torque_limit <= TORQ_FULL)
        else $error("torque limit above full");
    chk_gear_step: assert property (@(posedge mclk) disable iff (!rst_b)
        g_valid && eff[PNUM_GNUM] == eff[PNUM_GDEN] |-> g_delta == 12'sd1 || g_delta == -12'sd1)
        else $error("unity gear gave wrong step");
endmodule

/* File: verilog/spf_gear.sv */
// Purpose: electronic gear, pulses times numerator over denominator
// Assumes: numerator and denominator 1 to 999, one input step per cycle at most
// Notes: remainder held between pulses so long runs do not drift
`timescale 1ns/1ps
module spf_gear
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic step,
    input wire logic dir,
    input wire logic [11:0] gear_numerator,
    input wire logic [11:0] gear_denominator,
    output logic out_valid,
    output logic signed [11:0] out_delta
);
    import spf_pkg::*;
    logic [12:0] acc;
    logic [12:0] sum;
    logic [11:0] quo;
    logic [12:0] rem;
    logic [22:0] den_sh;
    always_comb
    begin
        sum = acc + {1'b0, gear_numerator};
        quo = 12'h000;
        rem = sum;
        den_sh = 23'h000000;
        // restoring division; shifted divisor kept wide so no high bit wraps to zero
        for (int i = 0; i < 11; i++)
        begin
            den_sh = {11'h000, gear_denominator} << (10 - i);
            if ({10'h000, rem} >= den_sh && gear_denominator != 12'h000)
            begin
                rem = rem - den_sh[12:0];
                quo[10 - i] = 1'b1;
            end
        end
    end
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc <= 13'h0000;
            out_valid <= 1'b0;
            out_delta <= 12'sh000;
        end
        else
        begin
            out_valid <= step;
            if (step)
            begin
                acc <= rem;
                out_delta <= dir ? -$signed(quo) : $signed(quo);
            end
        end
    end
    chk_gear_remainder: assert property (@(posedge mclk) disable iff (!rst_b)
        gear_denominator != 12'h000 |-> acc < {1'b0, gear_denominator})
        else $error("gear remainder not below denominator");
endmodule
